// ### core/fsg_slave.sv
// Summary of operation
// - Five states; moves only on master request, master drives every transition.
// - Firmware-update state entered only from the initialisation state.
// - Firmware-update state passes only file-access mailbox traffic, no process data.
// - Initialisation resets communication state; no mailbox, no process data.
// - Pre-operational services mailbox; process data transmit and receive disabled.
// - Safe-operational services mailbox, sends inputs, ignores received outputs.
// - Operational services mailbox, sends and accepts process data.
// - Process data cyclic with each frame; mailbox acyclic on demand.
// - Cyclic payload built only from the configured mapping entries.
// - Every dictionary object readable and writable through the mailbox.
// - Own data inserted into the passing frame on the fly.
`timescale 1ns/10ps
`default_nettype none

module fsg_slave #(
    parameter logic [7:0] PD_OFS = fsg_pkg::FSG_PD_OFS
) (
    input  wire logic                           sys_clk,
    input  wire logic                           rst_n,
    input  wire logic                           req_valid,
    input  wire fsg_pkg::fsg_al_type            req_state,
    input  wire logic                           mbx_valid,
    input  wire logic                           mbx_write,
    input  wire logic                           mbx_file,
    input  wire logic [fsg_pkg::FSG_IDX_W-1:0]  mbx_idx,
    input  wire logic [fsg_pkg::FSG_OBJ_W-1:0]  mbx_wdata,
    output logic                                mbx_rsp_valid,
    output logic                                mbx_rsp_ok,
    output logic [fsg_pkg::FSG_OBJ_W-1:0]       mbx_rsp_data,
    output logic                                fw_valid,
    output logic [fsg_pkg::FSG_OBJ_W-1:0]       fw_data,
    input  wire logic                           app_wr,
    input  wire logic [fsg_pkg::FSG_IDX_W-1:0]  app_idx,
    input  wire logic [fsg_pkg::FSG_OBJ_W-1:0]  app_wdata,
    output logic                                app_rx_valid,
    output logic [fsg_pkg::FSG_IDX_W-1:0]       app_rx_idx,
    output logic [fsg_pkg::FSG_OBJ_W-1:0]       app_rx_data,
    input  wire logic                           frm_in_valid,
    input  wire logic                           frm_in_sof,
    input  wire logic [7:0]                     frm_in_data,
    output logic                                frm_out_valid,
    output logic [7:0]                          frm_out_data,
    output fsg_pkg::fsg_al_type                 al_state,
    output logic                                al_error,
    output logic                                mbx_en,
    output logic                                pd_tx_en,
    output logic                                pd_rx_en
);
    import fsg_pkg::*;

    typedef struct packed {
        fsg_al_type            al;
        logic                  err;
        logic                  mbe;
        logic                  txe;
        logic                  rxe;
        logic [7:0]            bcnt;
        logic [7:0]            lo;
        logic                  fov;
        logic [7:0]            fdat;
        logic                  rv;
        logic                  ok;
        logic [FSG_OBJ_W-1:0]  rd;
        logic                  fwv;
        logic [FSG_OBJ_W-1:0]  fwd;
        logic                  arv;
        logic [FSG_IDX_W-1:0]  ari;
        logic [FSG_OBJ_W-1:0]  ard;
    } fsg_top_type;

    localparam fsg_top_type FSG_TOP_RST = '{
        al: FSG_INIT, err: 1'b0, mbe: 1'b0, txe: 1'b0, rxe: 1'b0,
        bcnt: 8'h00, lo: 8'h00, fov: 1'b0, fdat: 8'h00, rv: 1'b0, ok: 1'b0,
        rd: 16'h0000, fwv: 1'b0, fwd: 16'h0000, arv: 1'b0, ari: 4'h0,
        ard: 16'h0000};

    fsg_top_type q;
    fsg_top_type next_q;

    fsg_dict_if dif ();

    fsg_dict u_dict (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .dif     (dif)
    );

    // ------------------------------------------------------------
    // Transition table
    // ------------------------------------------------------------
    function automatic logic fsg_allowed(fsg_al_type cur, fsg_al_type req);
        logic ok;
        ok = 1'b0;
        if (req == cur || req == FSG_INIT) begin
            ok = 1'b1;
        end else begin
            case (cur)
                FSG_INIT:   ok = (req == FSG_PREOP) || (req == FSG_BOOT);
                FSG_PREOP:  ok = (req == FSG_SAFEOP);
                FSG_SAFEOP: ok = (req == FSG_OP) || (req == FSG_PREOP);
                FSG_OP:     ok = (req == FSG_SAFEOP) || (req == FSG_PREOP);
                default:    ok = 1'b0;
            endcase
        end
        return ok;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic [7:0]            pos;
    logic [7:0]            slot;
    logic [FSG_MAP_W-1:0]  k;
    logic [FSG_IDX_W-1:0]  txobj;
    logic [FSG_IDX_W-1:0]  rxobj;
    logic [FSG_OBJ_W-1:0]  txval;
    logic                  in_tx;
    logic                  in_rx;

    always_comb begin
        next_q      = q;
        next_q.rv   = 1'b0;
        next_q.fwv  = 1'b0;
        next_q.arv  = 1'b0;
        dif.wr      = 1'b0;
        dif.widx    = '0;
        dif.wdata   = '0;

        // State requests
        if (req_valid) begin
            if (fsg_allowed(q.al, req_state)) begin
                next_q.al  = req_state;
                next_q.err = 1'b0;
                if (req_state == FSG_INIT) begin
                    next_q.lo = 8'h00;
                end
            end else begin
                next_q.err = 1'b1;
            end
        end
        // Gates follow the state; registered so ports come from flops
        next_q.mbe = (next_q.al == FSG_PREOP) || (next_q.al == FSG_SAFEOP)
                   || (next_q.al == FSG_OP);
        next_q.txe = (next_q.al == FSG_SAFEOP) || (next_q.al == FSG_OP);
        next_q.rxe = (next_q.al == FSG_OP);

        // Frame passes with one cycle of latency, never buffered whole
        pos   = frm_in_sof ? 8'h00 : q.bcnt;
        slot  = 8'(pos - PD_OFS);
        k     = slot[FSG_MAP_W:1];
        in_tx = (pos >= PD_OFS) && (slot < FSG_PD_BYTES);
        in_rx = (pos >= PD_OFS) && (slot >= FSG_PD_BYTES)
              && (slot < 8'(FSG_PD_BYTES + FSG_PD_BYTES));
        txobj = dif.ent[4'(FSG_TXMAP_BASE + {2'b00, k})][FSG_IDX_W-1:0];
        rxobj = dif.ent[4'(FSG_RXMAP_BASE + {2'b00, k})][FSG_IDX_W-1:0];
        txval = dif.ent[txobj];
        next_q.fov  = frm_in_valid;
        next_q.fdat = frm_in_data;
        if (frm_in_valid) begin
            next_q.bcnt = (pos == FSG_BCNT_MAX) ? pos : 8'(pos + 8'h01);
            if (in_tx && q.txe) begin
                next_q.fdat = slot[0] ? txval[15:8] : txval[7:0];
            end
            if (in_rx && q.rxe) begin
                if (!slot[0]) begin
                    next_q.lo = frm_in_data;
                end else begin
                    dif.wr     = 1'b1;
                    dif.widx   = rxobj;
                    dif.wdata  = {frm_in_data, q.lo};
                    next_q.arv = 1'b1;
                    next_q.ari = rxobj;
                    next_q.ard = {frm_in_data, q.lo};
                end
            end
        end

        // Mailbox, served whenever a request arrives
        if (mbx_valid) begin
            next_q.rv = 1'b1;
            next_q.rd = dif.ent[mbx_idx];
            if (mbx_file) begin
                next_q.ok = (q.al == FSG_BOOT);
                if (q.al == FSG_BOOT && mbx_write) begin
                    next_q.fwv = 1'b1;
                    next_q.fwd = mbx_wdata;
                end
            end else if (q.mbe && mbx_write) begin
                // Write port busy with received process data: refuse, retry
                next_q.ok = !dif.wr;
                if (!dif.wr) begin
                    dif.wr    = 1'b1;
                    dif.widx  = mbx_idx;
                    dif.wdata = mbx_wdata;
                end
            end else begin
                next_q.ok = q.mbe;
            end
        end

        // Drive publishes its actual values; lowest priority, may be dropped
        if (app_wr && !dif.wr) begin
            dif.wr    = 1'b1;
            dif.widx  = app_idx;
            dif.wdata = app_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            q <= FSG_TOP_RST;
        end else begin
            q <= next_q;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign al_state      = q.al;
    assign al_error      = q.err;
    assign mbx_en        = q.mbe;
    assign pd_tx_en      = q.txe;
    assign pd_rx_en      = q.rxe;
    assign frm_out_valid = q.fov;
    assign frm_out_data  = q.fdat;
    assign mbx_rsp_valid = q.rv;
    assign mbx_rsp_ok    = q.ok;
    assign mbx_rsp_data  = q.rd;
    assign fw_valid      = q.fwv;
    assign fw_data       = q.fwd;
    assign app_rx_valid  = q.arv;
    assign app_rx_idx    = q.ari;
    assign app_rx_data   = q.ard;
endmodule

`default_nettype wire

// ### core/fsg_pkg.sv
package fsg_pkg;

    // ------------------------------------------------------------
    // Communication states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        FSG_INIT   = 3'h0,
        FSG_PREOP  = 3'h1,
        FSG_SAFEOP = 3'h3,
        FSG_OP     = 3'h2,
        FSG_BOOT   = 3'h4
    } fsg_al_type;

    // ------------------------------------------------------------
    // Object dictionary layout
    // ------------------------------------------------------------
    localparam int         FSG_DICT_N      = 16;
    localparam int         FSG_IDX_W       = 4;
    localparam int         FSG_OBJ_W       = 16;
    localparam int         FSG_MAP_N       = 4;
    localparam int         FSG_MAP_W       = 2;
    localparam logic [3:0] FSG_TXMAP_BASE  = 4'h8;
    localparam logic [3:0] FSG_RXMAP_BASE  = 4'hc;
    localparam logic [3:0] FSG_TXMAP_RST   = 4'h0;
    localparam logic [3:0] FSG_RXMAP_RST   = 4'h4;
    localparam logic [15:0] FSG_OBJ_RST    = 16'h0000;

    // ------------------------------------------------------------
    // Process data area inside the passing frame
    // ------------------------------------------------------------
    localparam logic [7:0] FSG_PD_OFS      = 8'h10;
    localparam logic [7:0] FSG_PD_BYTES    = 8'h08;
    localparam logic [7:0] FSG_BCNT_MAX    = 8'hff;

endpackage

// ### core/fsg_dict_if.sv
`timescale 1ns/10ps
`default_nettype none

interface fsg_dict_if;
    import fsg_pkg::*;

    logic                                  wr;
    logic [FSG_IDX_W-1:0]                  widx;
    logic [FSG_OBJ_W-1:0]                  wdata;
    logic [FSG_DICT_N-1:0][FSG_OBJ_W-1:0]  ent;

    modport user  (output wr, output widx, output wdata, input ent);
    modport store (input wr, input widx, input wdata, output ent);
endinterface

`default_nettype wire

// ### core/fsg_dict.sv
`timescale 1ns/10ps
`default_nettype none

module fsg_dict (
    input  wire logic  sys_clk,
    input  wire logic  rst_n,
    fsg_dict_if.store  dif
);
    import fsg_pkg::*;

    typedef struct packed {
        logic [FSG_DICT_N-1:0][FSG_OBJ_W-1:0] ent;
    } fsg_dict_type;

    // ------------------------------------------------------------
    // Reset image: mapping entries point at default objects
    // ------------------------------------------------------------
    function automatic fsg_dict_type fsg_rst_image();
        fsg_dict_type r;
        for (int i = 0; i < FSG_DICT_N; i++) begin
            r.ent[i] = FSG_OBJ_RST;
        end
        for (int k = 0; k < FSG_MAP_N; k++) begin
            r.ent[int'(FSG_TXMAP_BASE) + k] = 16'(int'(FSG_TXMAP_RST) + k);
            r.ent[int'(FSG_RXMAP_BASE) + k] = 16'(int'(FSG_RXMAP_RST) + k);
        end
        return r;
    endfunction

    localparam fsg_dict_type FSG_DICT_RST = fsg_rst_image();

    fsg_dict_type q;
    fsg_dict_type next_q;

    always_comb begin
        next_q = q;
        if (dif.wr) begin
            next_q.ent[dif.widx] = dif.wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            q <= FSG_DICT_RST;
        end else begin
            q <= next_q;
        end
    end

    assign dif.ent = q.ent;
endmodule

`default_nettype wire

// ### bench/fsg_slave_props.sv
`timescale 1ns/10ps
`default_nettype none

module fsg_slave_props (
    input wire logic                           sys_clk,
    input wire logic                           rst_n,
    input wire logic                           req_valid,
    input wire fsg_pkg::fsg_al_type            req_state,
    input wire logic                           mbx_valid,
    input wire logic                           mbx_write,
    input wire logic                           mbx_file,
    input wire logic [fsg_pkg::FSG_OBJ_W-1:0]  mbx_wdata,
    input wire logic                           mbx_rsp_valid,
    input wire logic                           mbx_rsp_ok,
    input wire logic                           fw_valid,
    input wire logic [fsg_pkg::FSG_OBJ_W-1:0]  fw_data,
    input wire logic                           app_rx_valid,
    input wire logic                           frm_in_valid,
    input wire logic [7:0]                     frm_in_data,
    input wire logic                           frm_out_valid,
    input wire logic [7:0]                     frm_out_data,
    input wire fsg_pkg::fsg_al_type            al_state,
    input wire logic                           al_error,
    input wire logic                           mbx_en,
    input wire logic                           pd_tx_en,
    input wire logic                           pd_rx_en
);
    import fsg_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // --------------------------------
    // State and gating
    // --------------------------------
    AST_HOLD: assert property (!req_valid |=> $stable(al_state))
        else $error("State moved without request");
    AST_LAT: assert property (
        req_valid && al_state == FSG_INIT && req_state == FSG_PREOP
        |=> al_state == FSG_PREOP && !al_error && mbx_en)
        else $error("Init to preop not answered in one cycle");
    AST_BOOT_GATE: assert property (
        req_valid && req_state == FSG_BOOT && !(al_state inside {FSG_INIT, FSG_BOOT})
        |=> al_state == $past(al_state) && al_error)
        else $error("Boot entered from wrong state");
    AST_MBX_EN: assert property (mbx_en == (al_state inside {FSG_PREOP, FSG_SAFEOP, FSG_OP}))
        else $error("Mailbox enable wrong for state");
    AST_PD_EN: assert property (
        pd_tx_en == (al_state inside {FSG_SAFEOP, FSG_OP}) && pd_rx_en == (al_state == FSG_OP))
        else $error("Process data enables wrong for state");
    AST_MBX_OFF: assert property (
        mbx_valid && !mbx_file && al_state inside {FSG_INIT, FSG_BOOT}
        |=> mbx_rsp_valid && !mbx_rsp_ok)
        else $error("Mailbox served while closed");
    AST_FW: assert property (
        mbx_valid && mbx_write && mbx_file && al_state == FSG_BOOT
        |=> fw_valid && mbx_rsp_ok && fw_data == $past(mbx_wdata))
        else $error("File write in boot not accepted");
    // Two cycles of slack: pulse follows the byte edge
    AST_RX_GATE: assert property (app_rx_valid |-> $past(pd_rx_en) || $past(pd_rx_en, 2))
        else $error("Received data applied while blocked");
    AST_PASS: assert property (
        frm_in_valid && !pd_tx_en |=> frm_out_valid && frm_out_data == $past(frm_in_data))
        else $error("Byte not forwarded in one cycle");
endmodule

bind fsg_slave fsg_slave_props i_props (.sys_clk, .rst_n, .req_valid, .req_state, .mbx_valid, .mbx_write, .mbx_file,
    .mbx_wdata, .mbx_rsp_valid, .mbx_rsp_ok, .fw_valid, .fw_data, .app_rx_valid, .frm_in_valid, .frm_in_data,
    .frm_out_valid, .frm_out_data, .al_state, .al_error, .mbx_en, .pd_tx_en, .pd_rx_en);

`default_nettype wire

// ### bench/fsg_master_model.sv
`timescale 1ns/10ps
`default_nettype none

module fsg_master_model (
    input  wire logic           sys_clk,
    output logic                req_valid,
    output fsg_pkg::fsg_al_type req_state
);
    import fsg_pkg::*;
    initial begin
        req_valid = 1'b0;
        req_state = FSG_INIT;
    end
    // Only the master starts a transition; code shown inverted once released
    task automatic issue(input logic [2:0] code);
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req_state <= fsg_al_type'(code);
        @(posedge sys_clk);
        req_valid <= 1'b0;
        req_state <= fsg_al_type'(~code);
    endtask
endmodule

`default_nettype wire

// ### bench/tb_fsg_slave.sv
`timescale 1ns/10ps
`default_nettype none

module tb_fsg_slave;
    import fsg_pkg::*;
    logic        sys_clk = 0, rst_n = 0, req_valid, mbx_valid = 0, mbx_write = 0, mbx_file = 0, app_wr = 0;
    logic        frm_in_valid = 0, frm_in_sof = 0, mbx_rsp_valid, mbx_rsp_ok, fw_valid, app_rx_valid;
    logic        frm_out_valid, al_error, mbx_en, pd_tx_en, pd_rx_en;
    logic [3:0]  mbx_idx = 0, app_idx = 0, app_rx_idx;
    logic [15:0] mbx_wdata = 0, app_wdata = 0, mbx_rsp_data, fw_data, app_rx_data;
    logic [7:0]  frm_in_data = 0, frm_out_data;
    fsg_al_type  req_state, al_state;
    int          errors = 0, samples_checked = 0, seed = 32'h9a62d5d3, st = 0, t;
    int          up[5] = '{1, 3, 2, 2, 0};
    logic [15:0] dict[16] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 2, 3, 4, 5, 6, 7};
    logic [15:0] ai, aw;

    always #5 sys_clk = ~sys_clk;

    fsg_master_model i_mst (.sys_clk, .req_valid, .req_state);
    fsg_slave i_dut (.sys_clk, .rst_n, .req_valid, .req_state, .mbx_valid, .mbx_write, .mbx_file, .mbx_idx,
        .mbx_wdata, .mbx_rsp_valid, .mbx_rsp_ok, .mbx_rsp_data, .fw_valid, .fw_data, .app_wr, .app_idx, .app_wdata,
        .app_rx_valid, .app_rx_idx, .app_rx_data, .frm_in_valid, .frm_in_sof, .frm_in_data, .frm_out_valid,
        .frm_out_data, .al_state, .al_error, .mbx_en, .pd_tx_en, .pd_rx_en);

    // --------------------------------
    // Compare and close
    // --------------------------------
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_state(input fsg_al_type got, input fsg_al_type exp);
        cmp(16'(got), 16'(exp));
    endtask
    task automatic conclude();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    function automatic logic legal(input int c, input int n);
        return n == c || n == 0 || (c == 0 && (n == 1 || n == 4)) || (c == 1 && n == 3)
            || (c > 1 && c < 4 && n > 0 && n < 4);
    endfunction

    // --------------------------------
    // Bus cycles
    // --------------------------------
    task automatic mbx(input logic wr, input logic fl, input logic [3:0] idx, input logic [15:0] wd);
        logic ok;
        ok = fl ? st == 4 : (st > 0 && st < 4);
        @(posedge sys_clk);
        {mbx_valid, mbx_write, mbx_file, mbx_idx, mbx_wdata} <= {1'b1, wr, fl, idx, wd};
        @(posedge sys_clk);
        {mbx_valid, mbx_write, mbx_file, mbx_idx, mbx_wdata} <= {1'b0, ~wr, ~fl, ~idx, ~wd};
        #1;
        cmp({mbx_rsp_valid, mbx_rsp_ok}, {1'b1, ok});
        cmp(mbx_rsp_data, dict[idx]);
        if (wr && fl && ok) cmp({fw_valid, fw_data}, {1'b1, wd});
        if (wr && ok) dict[idx] = wd;
    endtask
    // Cyclic frame with tx area then rx area
    task automatic frame();
        logic [7:0]  b[32];
        logic [7:0]  lo, exp;
        logic [15:0] w;
        logic [3:0]  ri;
        logic        rxw;
        int          s;
        for (int p = 0; p <= 32; p++) begin
            @(posedge sys_clk);
            if (p < 32) b[p] = 8'($random(seed));
            {frm_in_valid, frm_in_sof, frm_in_data} <= (p < 32) ? {1'b1, p == 0, b[p]} : {2'b00, ~b[31]};
            #1;
            if (p > 0) begin
                s = p - 1 - int'(FSG_PD_OFS);
                exp = b[p-1];
                rxw = 1'b0;
                if (s >= 0 && s < 8 && (st == 2 || st == 3)) begin
                    w = dict[dict[int'(FSG_TXMAP_BASE) + s / 2][3:0]];
                    exp = s[0] ? w[15:8] : w[7:0];
                end
                if (s >= 8 && s < 16 && st == 2) begin
                    if (s[0]) begin
                        ri = dict[int'(FSG_RXMAP_BASE) + (s - 8) / 2][3:0];
                        dict[ri] = {exp, lo};
                        rxw = 1'b1;
                        cmp(app_rx_idx, ri);
                        cmp(app_rx_data, {exp, lo});
                    end else begin
                        lo = exp;
                    end
                end
                cmp(app_rx_valid, rxw);
                cmp({frm_out_valid, frm_out_data}, {1'b1, exp});
            end
        end
    endtask

    initial begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1;
        cmp_state(al_state, FSG_INIT);
        cmp({al_error, mbx_en, pd_tx_en, pd_rx_en}, 4'h0);
        for (int i = 0; i < 90; i++) begin
            t = ($random(seed) & 8) ? up[st] : ($random(seed) & 7);
            i_mst.issue(3'(t));
            #1;
            cmp(al_error, !legal(st, t));
            if (legal(st, t)) st = t;
            cmp_state(al_state, fsg_al_type'(st));
            cmp({mbx_en, pd_tx_en, pd_rx_en}, {st > 0 && st < 4, st == 2 || st == 3, st == 2});
            ai = 16'($random(seed));
            aw = (st == 4 || ($random(seed) & 7) == 0) ? 16'h1 : 16'h0;
            mbx(1'($random(seed)), aw[0], ai[3:0], aw[0] ? dict[ai[3:0]] : 16'($random(seed)));
            aw = 16'($random(seed));
            @(posedge sys_clk);
            {app_wr, app_idx, app_wdata} <= {1'b1, ai[7:4], aw};
            @(posedge sys_clk);
            {app_wr, app_idx, app_wdata} <= {1'b0, ~ai[7:4], ~aw};
            dict[ai[7:4]] = aw;
            frame();
        end
        conclude();
    end
endmodule

`default_nettype wire
